//--- common/fcr_pkg.sv
// fcr_pkg: constants, types and register map of the fan control register core.
// assumes a 50 MHz system clock and a separate pulse_overflow_alarm sampling clock.
package fcr_pkg;
	// register command codes
	localparam logic [7:0] ADDR_SPEED = 8'h00; // closed-loop target period
	localparam logic [7:0] ADDR_CFG = 8'h02; // fan_mode_config
	localparam logic [7:0] ADDR_PINFN = 8'h04; // pin_function_select
	localparam logic [7:0] ADDR_DAC = 8'h06; // open-loop drive value
	localparam logic [7:0] ADDR_MASK = 8'h08; // alarm_mask
	localparam logic [7:0] ADDR_FLAGS = 8'h0A; // alarm_flags
	localparam logic [7:0] ADDR_TACH0 = 8'h0C; // pulse_overflow_alarm counts, stride 2
	localparam logic [7:0] ADDR_TACH3 = 8'h12;
	localparam logic [7:0] ADDR_PINLVL = 8'h14; // pin_level_readback
	localparam logic [7:0] ADDR_COUNT = 8'h16; // window_length_code
	// reset values
	localparam logic [7:0] RST_SPEED = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h0A;
	localparam logic [7:0] RST_PINFN = 8'hFF;
	localparam logic [7:0] RST_DAC = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [4:0] RST_PINLVL = 5'h1F;
	localparam logic [1:0] RST_COUNT = 2'h2;
	// config fields
	localparam int CFG_MODE_LSB = 4;
	localparam int CFG_VSEL_BIT = 3;
	localparam int CFG_SCALE_LSB = 0;
	// pin function fields
	localparam int PF_ALERT_LSB = 0;
	localparam int PF_OVR_LSB = 2;
	localparam int PF_CSYNC_LSB = 4;
	localparam int PF_SPARE_A_BIT = 6;
	localparam int PF_SPARE_B_BIT = 7;
	// alarm bit positions
	localparam int AL_MAX = 0;
	localparam int AL_MIN = 1;
	localparam int AL_OVF = 2;
	localparam int AL_OVR = 3;
	localparam int AL_CSYNC = 4;
	// timing
	localparam int SYS_CLK_KHZ = 50000;
	localparam int WIN_BASE_MS = 250; // window base, 0.25 s
	localparam int WIN_BASE_CYC = WIN_BASE_MS * SYS_CLK_KHZ;
	localparam int OSC_KHZ = 254; // nominal regulator oscillator
	localparam int OSC_DIV = 128; // period tick is 128 oscillator clocks
	localparam int PER_TICK_CYC = (OSC_DIV * SYS_CLK_KHZ) / OSC_KHZ;
	localparam int CLKOUT_HALF_CYC = SYS_CLK_KHZ / (2 * OSC_KHZ);
	localparam logic [7:0] DRIVE_MAX = 8'hFF;
	localparam logic [7:0] DRIVE_MIN = 8'h00;
	localparam logic [7:0] PULSE_OVERFLOW_ALARM_SAT = 8'hFF;
	// operating modes
	typedef enum logic [1:0] {
		MODE_FULL = 2'b00,
		MODE_OFF = 2'b01,
		MODE_CLOSED = 2'b10,
		MODE_OPEN = 2'b11
	} fcr_mode_e;
	// one register access
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} fcr_req_s;
	// open-drain pin group
	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe_n;
	} fcr_pin_s;
endpackage : fcr_pkg

//--- logic/fcr_core.sv
// fcr_core: registers, mode select, pins, alarms and pulse_overflow_alarm counters.
// assumes a protocol engine in front issues one-cycle rd/wr strobes.
// How it works
// - mode from config 5:4, voltage bit 3
// - prescaler from config 2:0 scales period
// - closed loop steers drive toward target period
// - full-speed mode applies maximum drive
// - override pin low forces full drive
// - pins released after reset
// - pin levels read back in bits 4:0
// - function 1:0 controls alert pin
// - function 3:2 controls override pin
// - function 5:4 controls clock-sync pin
// - function 7,6 control spare pins b,a
// - alert pin low on enabled fault
// - alarms active only when mask bit set
// - min/max alarms only in closed loop
// - flags share mask bit positions
// - flag read clears only vanished causes
// - pulse_overflow_alarm counts pulses over the window
// - count saturates at 255, flags overflow
// - three extra pulse_overflow_alarm inputs counted
// - window 0.25s times two to K
// - target period used only closed loop
module fcr_core #(
	parameter int WIN_CYC = fcr_pkg::WIN_BASE_CYC, // base window cycles
	parameter int TICK_CYC = fcr_pkg::PER_TICK_CYC // period tick cycles
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic tachClk,
	input wire fcr_pkg::fcr_req_s regReq,
	output logic [7:0] regRdata,
	input wire logic [4:0] pinIn,
	output fcr_pkg::fcr_pin_s pinDrv,
	input wire logic [3:0] tachIn,
	output logic [7:0] fanDrive,
	output logic fanVoltageSelect
);
	import fcr_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic [7:0] speedTarget; // closed-loop target period
	logic [7:0] cfg; // fan_mode_config
	logic [7:0] pinFunc; // pin_function_select
	logic [7:0] dacValue; // open-loop drive
	logic [4:0] alarmMask; // alarm_mask
	logic [4:0] alarmFlags; // alarm_flags
	logic [1:0] windowLengthCode; // count window code
	logic [7:0] tachCount [4]; // published counts
	fcr_mode_e mode;
	logic [2:0] scale;
	logic regWrite;
	logic alarmRd;

	assign mode = fcr_mode_e'(cfg[CFG_MODE_LSB +: 2]);
	assign scale = (cfg[CFG_SCALE_LSB +: 3] > 3'h4) ? 3'h4
		: cfg[CFG_SCALE_LSB +: 3];
	assign regWrite = regReq.wr;
	assign alarmRd = regReq.rd && (regReq.addr == ADDR_FLAGS);
	// software writes; read-only addresses ignore writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			speedTarget <= RST_SPEED;
			cfg <= RST_CFG;
			pinFunc <= RST_PINFN;
			dacValue <= RST_DAC;
			alarmMask <= RST_MASK[4:0];
			windowLengthCode <= RST_COUNT;
		end else if (regWrite) begin
			unique case (regReq.addr)
				ADDR_SPEED: speedTarget <= regReq.wdata;
				ADDR_CFG: cfg <= {2'b00, regReq.wdata[5:0]};
				ADDR_PINFN: pinFunc <= regReq.wdata;
				ADDR_DAC: dacValue <= regReq.wdata;
				ADDR_MASK: alarmMask <= regReq.wdata[4:0];
				ADDR_COUNT: windowLengthCode <= regReq.wdata[1:0];
				default: ;
			endcase
		end
	end
	// pin sampling: three flops, level moves when stages 2 and 3 agree
	logic [4:0] pinS1, pinS2, pinS3;
	logic [4:0] pinLvl; // filtered pin levels
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pinS1 <= RST_PINLVL;
			pinS2 <= RST_PINLVL;
			pinS3 <= RST_PINLVL;
			pinLvl <= RST_PINLVL;
		end else begin
			pinS1 <= pinIn;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			for (int i = 0; i < 5; i++) begin
				if (pinS2[i] == pinS3[i]) pinLvl[i] <= pinS2[i];
			end
		end
	end
	logic overrideAct; // hardware full-speed request
	assign overrideAct = (pinFunc[PF_OVR_LSB +: 2] == 2'b01)
		&& !pinLvl[1];
	// window timer: base window doubled K times
	logic [27:0] winCnt;
	logic [27:0] winLen;
	logic winTgl; // toggles once per finished window
	assign winLen = 28'(WIN_CYC) << windowLengthCode;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			winCnt <= 28'h0000000;
			winTgl <= 1'b0;
		end else if (winCnt >= winLen - 28'h0000001) begin
			winCnt <= 28'h0000000;
			winTgl <= ~winTgl;
		end else begin
			winCnt <= winCnt + 28'h0000001;
		end
	end
	// link side: pulse_overflow_alarm pulses counted on the pulse_overflow_alarm clock
	logic [2:0] winSyncL; // window toggle into pulse_overflow_alarm domain
	logic [3:0] tS1, tS2, tS3, tLvl;
	logic [7:0] liveCnt [4];
	logic [7:0] snapCnt [4]; // held stable between windows
	logic snapOvf; // any counter saturated in last window
	logic liveOvf;
	logic doneTgl; // snapshot ready, pulse_overflow_alarm domain
	logic pulse0Tgl; // tach0 edge event, pulse_overflow_alarm domain
	logic winEndL;
	logic [3:0] tachRise;
	assign winEndL = winSyncL[2] ^ winSyncL[1];
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			tachRise[i] = (tS2[i] == tS3[i]) && tS2[i] && !tLvl[i];
		end
	end
	always_ff @(posedge tachClk or negedge arst_n) begin
		if (!arst_n) begin
			winSyncL <= 3'b000;
			tS1 <= 4'h0;
			tS2 <= 4'h0;
			tS3 <= 4'h0;
			tLvl <= 4'h0;
			liveOvf <= 1'b0;
			snapOvf <= 1'b0;
			doneTgl <= 1'b0;
			pulse0Tgl <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				liveCnt[i] <= 8'h00;
				snapCnt[i] <= 8'h00;
			end
		end else begin
			winSyncL <= {winSyncL[1:0], winTgl};
			tS1 <= tachIn;
			tS2 <= tS1;
			tS3 <= tS2;
			for (int i = 0; i < 4; i++) begin
				if (tS2[i] == tS3[i]) tLvl[i] <= tS2[i];
			end
			if (tachRise[0]) pulse0Tgl <= ~pulse0Tgl;
			if (winEndL) begin
				// publish and restart; an edge in this cycle is dropped
				for (int i = 0; i < 4; i++) begin
					snapCnt[i] <= liveCnt[i];
					liveCnt[i] <= 8'h00;
				end
				snapOvf <= liveOvf;
				liveOvf <= 1'b0;
				doneTgl <= ~doneTgl;
			end else begin
				for (int i = 0; i < 4; i++) begin
					if (tachRise[i] && liveCnt[i] == PULSE_OVERFLOW_ALARM_SAT) begin
						liveOvf <= 1'b1;
					end else if (tachRise[i]) begin
						liveCnt[i] <= liveCnt[i] + 8'h01;
					end
				end
			end
		end
	end
	chk_pulse_overflow_alarm_saturate: assert property (@(posedge tachClk)
		disable iff (!arst_n) (!winEndL && tachRise[0]
		&& liveCnt[0] == PULSE_OVERFLOW_ALARM_SAT) |=> (liveCnt[0] == PULSE_OVERFLOW_ALARM_SAT && liveOvf))
		else $error("pulse_overflow_alarm count did not saturate");
	// back in system domain: snapshot and tach0 events
	logic [2:0] doneSync, p0Sync;
	logic snapEvt, tachEvt, ovfEvt;
	assign snapEvt = doneSync[2] ^ doneSync[1];
	assign tachEvt = p0Sync[2] ^ p0Sync[1];
	assign ovfEvt = snapEvt && snapOvf; // snapshot is stable here
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			doneSync <= 3'b000;
			p0Sync <= 3'b000;
			for (int i = 0; i < 4; i++) tachCount[i] <= 8'h00;
		end else begin
			doneSync <= {doneSync[1:0], doneTgl};
			p0Sync <= {p0Sync[1:0], pulse0Tgl};
			if (snapEvt) begin
				for (int i = 0; i < 4; i++) tachCount[i] <= snapCnt[i];
			end
		end
	end
	// period measurement in prescaled ticks
	logic [23:0] tickCnt;
	logic [23:0] tickLen;
	logic [15:0] perCnt; // ticks since last tach0 edge
	logic [15:0] perTarget;
	assign tickLen = 24'(TICK_CYC) >> scale;
	assign perTarget = {8'h00, speedTarget} + 16'h0001;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt <= 24'h000000;
			perCnt <= 16'h0000;
		end else begin
			if (tachEvt) begin
				tickCnt <= 24'h000000;
				perCnt <= 16'h0000;
			end else if (tickCnt >= tickLen - 24'h000001) begin
				tickCnt <= 24'h000000;
				if (perCnt != 16'hFFFF) perCnt <= perCnt + 16'h0001;
			end else begin
				tickCnt <= tickCnt + 24'h000001;
			end
		end
	end
	// closed-loop drive: one step per tach0 edge
	logic [7:0] loopDrive;
	logic atMin, atMax; // regulator pinned at a rail
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			loopDrive <= DRIVE_MAX;
			atMin <= 1'b0;
			atMax <= 1'b0;
		end else if (mode != MODE_CLOSED) begin
			// restart from full so the fan never stalls on entry
			loopDrive <= DRIVE_MAX;
			atMin <= 1'b0;
			atMax <= 1'b0;
		end else if (tachEvt) begin
			if (perCnt > perTarget) begin
				// too slow: more voltage
				atMin <= 1'b0;
				atMax <= (loopDrive == DRIVE_MAX);
				if (loopDrive != DRIVE_MAX) loopDrive <= loopDrive + 8'h01;
			end else if (perCnt < perTarget) begin
				// too fast: less voltage
				atMax <= 1'b0;
				atMin <= (loopDrive == DRIVE_MIN);
				if (loopDrive != DRIVE_MIN) loopDrive <= loopDrive - 8'h01;
			end else begin
				atMin <= 1'b0;
				atMax <= 1'b0;
			end
		end
	end
	// drive select; override beats every mode
	logic [7:0] next_fanDrive;
	always_comb begin
		unique case (mode)
			MODE_FULL: next_fanDrive = DRIVE_MAX;
			MODE_OFF: next_fanDrive = DRIVE_MIN;
			MODE_CLOSED: next_fanDrive = loopDrive;
			MODE_OPEN: next_fanDrive = dacValue;
		endcase
		if (overrideAct) next_fanDrive = DRIVE_MAX;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fanDrive <= DRIVE_MAX;
			fanVoltageSelect <= RST_CFG[CFG_VSEL_BIT];
		end else begin
			fanDrive <= next_fanDrive;
			fanVoltageSelect <= cfg[CFG_VSEL_BIT];
		end
	end
	chk_full_drive: assert property ((mode == MODE_FULL)
		|=> (fanDrive == DRIVE_MAX))
		else $error("full mode did not drive maximum");
	chk_override_wins: assert property (overrideAct
		|=> (fanDrive == DRIVE_MAX))
		else $error("override did not force full drive");
	chk_off_drive: assert property (
		(mode == MODE_OFF && !overrideAct) |=> (fanDrive == DRIVE_MIN))
		else $error("off mode left drive on");
	// alarm causes and sticky flags; set beats read-clear
	logic [4:0] cause; // live conditions
	logic [4:0] next_alarmFlags;
	always_comb begin
		cause = 5'h00;
		cause[AL_CSYNC] = !pinLvl[2];
		cause[AL_OVR] = !pinLvl[1];
		cause[AL_OVF] = ovfEvt; // event only
		cause[AL_MIN] = (mode == MODE_CLOSED) && atMin;
		cause[AL_MAX] = (mode == MODE_CLOSED) && atMax;
		next_alarmFlags = alarmFlags;
		if (alarmRd) next_alarmFlags = alarmFlags & cause;
		next_alarmFlags = next_alarmFlags | (cause & alarmMask);
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) alarmFlags <= 5'h00;
		else alarmFlags <= next_alarmFlags;
	end
	sequence flagsHeld;
		alarmFlags[AL_OVR] && !pinLvl[1];
	endsequence
	chk_rc_keeps_cause: assert property ((alarmRd and flagsHeld)
		|=> alarmFlags[AL_OVR])
		else $error("read cleared a flag whose cause remains");
	chk_flag_sticky: assert property (!alarmRd
		|=> ((alarmFlags & $past(alarmFlags)) == $past(alarmFlags)))
		else $error("alarm flag dropped without a read");
	chk_mask_gates: assert property ((alarmMask[AL_OVR] == 1'b0
		&& !alarmFlags[AL_OVR]) |=> !alarmFlags[AL_OVR])
		else $error("masked alarm was raised");
	chk_minmax_closed: assert property ((mode != MODE_CLOSED) [*2]
		|-> !$rose(alarmFlags[AL_MIN]) && !$rose(alarmFlags[AL_MAX]))
		else $error("drive alarm raised outside closed loop");
	// clock-sync output divider
	logic [7:0] divCnt;
	logic clkOut;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt <= 8'h00;
			clkOut <= 1'b1;
		end else if (divCnt >= 8'(CLKOUT_HALF_CYC - 1)) begin
			divCnt <= 8'h00;
			clkOut <= ~clkOut;
		end else begin
			divCnt <= divCnt + 8'h01;
		end
	end
	// open-drain pulls: oe_n low pulls the pin low
	logic alertAct;
	logic [4:0] next_pull;
	assign alertAct = |(alarmFlags & alarmMask);
	always_comb begin
		next_pull = 5'h00;
		unique case (pinFunc[PF_ALERT_LSB +: 2])
			2'b01: next_pull[0] = alertAct;
			2'b10: next_pull[0] = 1'b1;
			default: next_pull[0] = 1'b0;
		endcase
		next_pull[1] = (pinFunc[PF_OVR_LSB +: 2] == 2'b10);
		unique case (pinFunc[PF_CSYNC_LSB +: 2])
			2'b01: next_pull[2] = !clkOut;
			2'b10: next_pull[2] = 1'b1;
			default: next_pull[2] = 1'b0; // input or external clock
		endcase
		next_pull[3] = !pinFunc[PF_SPARE_A_BIT];
		next_pull[4] = !pinFunc[PF_SPARE_B_BIT];
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) pinDrv <= '{out: 5'h00, oe_n: 5'h1F};
		else pinDrv <= '{out: 5'h00, oe_n: ~next_pull}; // sink only
	end
	chk_alert_pin: assert property (
		(pinFunc[1:0] == 2'b01 && alertAct) |=> !pinDrv.oe_n[0])
		else $error("alert pin not pulled on enabled fault");
	// read data, one cycle after the read strobe
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		unique case (regReq.addr)
			ADDR_SPEED: next_rdata = speedTarget;
			ADDR_CFG: next_rdata = cfg;
			ADDR_PINFN: next_rdata = pinFunc;
			ADDR_DAC: next_rdata = dacValue;
			ADDR_MASK: next_rdata = {3'b000, alarmMask};
			ADDR_FLAGS: next_rdata = {3'b000, alarmFlags};
			ADDR_PINLVL: next_rdata = {3'b000, pinLvl};
			ADDR_COUNT: next_rdata = {6'h00, windowLengthCode};
			default: begin
				if (regReq.addr >= ADDR_TACH0 && regReq.addr <= ADDR_TACH3
					&& !regReq.addr[0]) begin
					next_rdata = tachCount[2'(
						(regReq.addr - ADDR_TACH0) >> 1)];
				end
			end
		endcase
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) regRdata <= 8'h00;
		else if (regReq.rd) regRdata <= next_rdata;
	end
	sequence cfgRead;
		regReq.rd && regReq.addr == ADDR_CFG;
	endsequence
	chk_cfg_upper_zero: assert property (cfgRead
		|=> regRdata[7:6] == 2'b00)
		else $error("config upper bits not zero");
endmodule : fcr_core

//--- bench/fcr_fan_model.sv
// fcr_fan_model: four fans with pulse_overflow_alarm outputs, pull-ups on the pins.
// assumes the bench starts each fan and may pull pins low from outside.
module fcr_fan_model #(
	parameter int HALF_NS = 60 // fan 0 half period, fan i is i+1 slower
) (
	input wire logic [3:0] fanRun,
	input wire logic [4:0] pinOeN,
	input wire logic [4:0] extLow,
	output logic [3:0] tachOut,
	output logic [4:0] pinLvl
);
	timeunit 1ns;
	timeprecision 100ps;
	// wired-and: either side may sink, the pull-up wins otherwise
	assign pinLvl = pinOeN & ~extLow;
	// one pulse train per fan, low while stopped
	for (genvar i = 0; i < 4; i++) begin : g_fan
		logic t = 1'b0; // pulse_overflow_alarm level of this fan
		// rate scaled down with the short window, never near the sampler
		always begin
			#(HALF_NS * (i + 1));
			t = fanRun[i] ? ~t : 1'b0;
		end
		assign tachOut[i] = t;
	end
endmodule : fcr_fan_model

//--- bench/test_fan_control_regs_alarms.sv
// test_fan_control_regs_alarms: directed checks of the fan register core.
// assumes short window and tick parameters and the fan model beside it.
module test_fan_control_regs_alarms;
	timeunit 1ns;
	timeprecision 100ps;
	import fcr_pkg::*;
	localparam int WIN = 200; // short base window, 4000 ns
	localparam int TICK = 8; // short period tick
	localparam int LIMIT = 30000; // cycles before a hang is cut
	logic sys_clk;
	logic arst_n;
	logic tachClk;
	fcr_req_s regReq;
	logic [7:0] regRdata;
	logic [4:0] pinIn;
	fcr_pin_s pinDrv;
	logic [3:0] tachIn;
	logic [7:0] fanDrive;
	logic fanVoltageSelect;
	logic [3:0] fanRun; // fans spinning
	logic [4:0] extLow; // outside pull-downs
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;
	fcr_core #(.WIN_CYC(WIN), .TICK_CYC(TICK)) fcr_core_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .tachClk(tachClk),
		.regReq(regReq), .regRdata(regRdata), .pinIn(pinIn),
		.pinDrv(pinDrv), .tachIn(tachIn), .fanDrive(fanDrive),
		.fanVoltageSelect(fanVoltageSelect));
	fcr_fan_model fcr_fan_model_inst (.fanRun(fanRun),
		.pinOeN(pinDrv.oe_n), .extLow(extLow), .tachOut(tachIn),
		.pinLvl(pinIn));
	// system clock, 50 MHz
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// pulse_overflow_alarm clock, 30 ns, phase unrelated to the system clock
	initial begin
		tachClk = 1'b0;
		#7;
		forever #15 tachClk = ~tachClk;
	end
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	// one-cycle write strobe, taken at the rising edge between
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge sys_clk);
		regReq.addr = a;
		regReq.wdata = d;
		regReq.wr = 1'b1;
		@(negedge sys_clk);
		regReq.wr = 1'b0;
	endtask : wr
	// read data stands one edge after the strobe is taken
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		regReq.addr = a;
		regReq.rd = 1'b1;
		@(negedge sys_clk);
		regReq.rd = 1'b0;
		@(negedge sys_clk);
		d = regRdata;
	endtask : rd
	task automatic rdchk(logic [7:0] a, logic [7:0] e, string what);
		logic [7:0] d;
		rd(a, d);
		check(what, d, e);
	endtask : rdchk
	task automatic t_reset();
		logic [7:0] ra[10] = '{ADDR_SPEED, ADDR_CFG, ADDR_PINFN,
			ADDR_DAC, ADDR_MASK, ADDR_FLAGS, ADDR_TACH0, ADDR_TACH3,
			ADDR_PINLVL, ADDR_COUNT};
		logic [7:0] rv[10] = '{8'h00, 8'h0A, 8'hFF, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h1F, 8'h02};
		check("drive", fanDrive, 8'hFF);
		check("volt", {7'h00, fanVoltageSelect}, 8'h01);
		check("oe_n", {3'h0, pinDrv.oe_n}, 8'h1F);
		check("out", {3'h0, pinDrv.out}, 8'h00);
		for (int i = 0; i < 10; i++) begin
			rdchk(ra[i], rv[i], "reset");
		end
		wr(ADDR_PINLVL, 8'h00);
		rdchk(ADDR_PINLVL, 8'h1F, "read-only level");
		rdchk(8'h18, 8'h00, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_config();
		wr(ADDR_CFG, 8'hFF);
		rdchk(ADDR_CFG, 8'h3F, "cfg top bits");
		wr(ADDR_DAC, 8'h5A);
		wr(ADDR_SPEED, 8'h80);
		cyc(2);
		check("open drive", fanDrive, 8'h5A);
		wr(ADDR_CFG, 8'h10);
		cyc(2);
		check("off drive", fanDrive, 8'h00);
		check("volt", {7'h00, fanVoltageSelect}, 8'h00);
		// prescaler codes 0 to 4, full speed mode
		for (int s = 0; s < 5; s++) begin
			wr(ADDR_CFG, 8'h08 | 8'(s));
			rdchk(ADDR_CFG, 8'h08 | 8'(s), "scale");
		end
		check("full drive", fanDrive, 8'hFF);
		wr(ADDR_MASK, 8'hFF);
		rdchk(ADDR_MASK, 8'h1F, "mask top bits");
		wr(ADDR_COUNT, 8'hFF);
		rdchk(ADDR_COUNT, 8'h03, "count top bits");
		wr(ADDR_MASK, 8'h00);
		$display("test config done");
	endtask : t_config
	task automatic t_pins();
		logic [1:0] seen;
		wr(ADDR_PINFN, 8'h2A);
		cyc(6);
		check("low", {3'h0, pinDrv.oe_n}, 8'h00);
		rdchk(ADDR_PINLVL, 8'h00, "levels low");
		wr(ADDR_PINFN, 8'hC0);
		cyc(3);
		check("float", {3'h0, pinDrv.oe_n}, 8'h1F);
		// only spare b pulled, tells the two spare bits apart
		wr(ADDR_PINFN, 8'h7F);
		cyc(3);
		check("spare b", {3'h0, pinDrv.oe_n}, 8'h0F);
		// clock-sync as clock output must toggle
		wr(ADDR_PINFN, 8'hDF);
		seen = 2'b00;
		repeat (220) begin
			@(negedge sys_clk);
			seen[pinDrv.oe_n[2]] = 1'b1;
		end
		check("clock out", {6'h00, seen}, 8'h03);
		wr(ADDR_PINFN, 8'hFF);
		extLow = 5'h15;
		cyc(6);
		rdchk(ADDR_PINLVL, 8'h0A, "levels");
		rdchk(ADDR_FLAGS, 8'h00, "masked off");
		extLow = 5'h00;
		$display("test pins done");
	endtask : t_pins
	task automatic t_override();
		wr(ADDR_CFG, 8'h1A);
		wr(ADDR_PINFN, 8'hF5);
		wr(ADDR_MASK, 8'h18);
		extLow = 5'h06;
		cyc(6);
		check("override", fanDrive, 8'hFF);
		check("alert", {7'h00, pinDrv.oe_n[0]}, 8'h00);
		rdchk(ADDR_FLAGS, 8'h18, "pin flags");
		rdchk(ADDR_FLAGS, 8'h18, "cause held");
		extLow = 5'h00;
		cyc(6);
		check("off again", fanDrive, 8'h00);
		check("alert held", {7'h00, pinDrv.oe_n[0]}, 8'h00);
		rdchk(ADDR_FLAGS, 8'h18, "latched");
		rdchk(ADDR_FLAGS, 8'h00, "cleared");
		check("alert off", {7'h00, pinDrv.oe_n[0]}, 8'h01);
		wr(ADDR_MASK, 8'h00);
		wr(ADDR_PINFN, 8'hFF);
		wr(ADDR_CFG, 8'h0A);
		$display("test override done");
	endtask : t_override
	task automatic t_pulse_overflow_alarm();
		logic [7:0] d;
		int e;
		logic ok;
		wr(ADDR_MASK, 8'h04);
		fanRun = 4'hF;
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_COUNT, 8'(k));
			cyc(3 * (WIN << k));
			for (int i = 0; i < 4; i++) begin
				rd(ADDR_TACH0 + 8'(2 * i), d);
				e = ((WIN * 20) << k) / (120 * (i + 1));
				if (e > 255) begin
					check("saturated", d, PULSE_OVERFLOW_ALARM_SAT);
				end else begin
					ok = (d >= 8'(e - 2)) && (d <= 8'(e + 2));
					check("count", {7'h00, ok}, 8'h01);
				end
			end
			rdchk(ADDR_FLAGS, k == 3 ? 8'h04 : 8'h00, "overflow");
		end
		wr(ADDR_MASK, 8'h00);
		fanRun = 4'h0;
		// an overflow may land just after the last check; drop it
		rd(ADDR_FLAGS, d);
		$display("test pulse_overflow_alarm done");
	endtask : t_pulse_overflow_alarm
	task automatic t_closed();
		wr(ADDR_CFG, 8'h3A);
		wr(ADDR_DAC, 8'h40);
		wr(ADDR_MASK, 8'h03);
		cyc(20);
		rdchk(ADDR_FLAGS, 8'h00, "no level alarm");
		wr(ADDR_SPEED, 8'hFF);
		fanRun = 4'h1;
		wr(ADDR_CFG, 8'h2A);
		cyc(100);
		check("slowing", 8'(fanDrive < 8'hFF), 8'h01);
		cyc(2000);
		check("drive min", fanDrive, 8'h00);
		rdchk(ADDR_FLAGS, 8'h02, "min alarm");
		wr(ADDR_SPEED, 8'h00);
		cyc(2000);
		check("drive max", fanDrive, 8'hFF);
		rdchk(ADDR_FLAGS, 8'h03, "both");
		rdchk(ADDR_FLAGS, 8'h01, "max stays");
		wr(ADDR_CFG, 8'h3A);
		cyc(4);
		check("open ignores", fanDrive, 8'h40);
		rdchk(ADDR_FLAGS, 8'h01, "latched max");
		rdchk(ADDR_FLAGS, 8'h00, "open quiet");
		fanRun = 4'h0;
		$display("test closed done");
	endtask : t_closed
	// main sequence
	initial begin
		arst_n = 1'b0;
		regReq = '0;
		fanRun = 4'h0;
		extLow = 5'h00;
		repeat (2) @(negedge sys_clk);
		arst_n = 1'b1;
		t_reset();
		t_config();
		t_pins();
		t_override();
		t_pulse_overflow_alarm();
		t_closed();
		end_sim();
	end
endmodule : test_fan_control_regs_alarms
